//--- logic/e1_line_clock_pkg.sv
// Constants, register layout and carrier types for the E1 line clock and jitter control block.
// Assumes a single 50 MHz ref_clk that stands in for the crystal and its x4 PLL.
// Overview of operation
// - Sampling clock is the crystal frequency multiplied by four.
// - Line sampled on both PLL edges: 32 samples per unit interval.
// - With a valid line signal, receive clock is the recovered clock, via attenuator if in receive path.
// - No bipolar pulses on the receive inputs means carrier loss.
// - Alternate clock input is watched for presence; unused input is tied low.
// - Loss with alternate clock: alternate clock, via attenuator if in receive path.
// - Loss without alternate clock: centred crystal, or transmit clock via attenuator.
// - Attenuator in receive path restores near 50% duty receive clock.
// - Build-out codes 000-011 select normal and protected 75/120 ohm shapes.
// - Codes 100 and 110 select high return loss 75 ohm shapes.
// - Transmit pulses are independent of transmit clock duty; adds no jitter.
// - One control bit selects attenuator depth of 32 or 128 bits.
// - Path bit puts attenuator in receive or transmit path; disable removes it.
// - Attenuator output clock is the 8.192 MHz crystal divided by four.
// - Crystal is pulled by switching load capacitance to track line frequency.
// - Jitter past 120 or 28 UIpp makes the divider use 3.5 or 4.5.
// - Using 3.5 or 4.5 sets the limit trip flag at bit 5 of rx info.
// - Control register bit 1 disables the attenuator when set.
// - Control register bit 0 powers down the transmitter, line outputs floating.
package e1_line_clock_pkg;
    localparam longint CLK_HZ = 64'd50000000;
    localparam longint XTAL_HZ = 64'd8192000;
    localparam longint LINE_HZ = 64'd2048000;
    localparam longint PLL_MULT = 64'd4;
    localparam longint OVERSAMPLE = 64'd32;
    localparam int PHASE_W = 16;
    localparam int XACC_W = 24;
    // Phase step per ref_clk in a 2^16 unit interval: PLL clock, both edges, 32 slots per UI
    localparam logic [PHASE_W-1:0] UI_INC =
        PHASE_W'(((XTAL_HZ * PLL_MULT * 64'd2 / OVERSAMPLE) << PHASE_W) / CLK_HZ);
    // Crystal half-period ticks per ref_clk, as a fraction of 2^24
    localparam logic [XACC_W-1:0] XTAL_HALF_INC =
        XACC_W'(((XTAL_HZ * 64'd2) << XACC_W) / CLK_HZ);
    // Roughly 200 ppm of pull range
    localparam logic [XACC_W-1:0] XTAL_PULL_INC = XACC_W'(64'd1100);
    localparam logic [PHASE_W-1:0] PHASE_ALIGN = 16'h4000;
    localparam int HALF_UI_CYC = int'(CLK_HZ / (LINE_HZ * 64'd2));
    localparam logic [7:0] LOS_ZEROS = 8'h00FF;
    localparam int ALT_WINDOW_CYC = 4096;
    localparam int ALT_EXPECT = int'(LINE_HZ * 64'd4096 / CLK_HZ);
    localparam logic [12:0] ALT_MIN = 13'(ALT_EXPECT * 3 / 4);
    localparam logic [12:0] ALT_MAX = 13'(ALT_EXPECT * 5 / 4);
    // Crystal half periods per output clock: 8 nominal (/4), 7 (/3.5), 9 (/4.5)
    localparam logic [3:0] DIV_NOM = 4'h8;
    localparam logic [3:0] DIV_FAST = 4'h7;
    localparam logic [3:0] DIV_SLOW = 4'h9;
    localparam int DEPTH_DEEP = 128;
    localparam int DEPTH_SHALLOW = 32;
    localparam int JITTER_DEEP = 120;
    localparam int JITTER_SHALLOW = 28;
    localparam logic [7:0] LIM_DEEP = 8'((DEPTH_DEEP - JITTER_DEEP) / 2);
    localparam logic [7:0] LIM_SHALLOW = 8'((DEPTH_SHALLOW - JITTER_SHALLOW) / 2);
    localparam logic [7:0] ADDR_LINE_IFACE_CTRL = 8'h0018;
    localparam logic [7:0] ADDR_RX_INFO_REG = 8'h0008;
    localparam logic [7:0] LINE_IFACE_CTRL_RESET = 8'h0000;
    localparam int RIR_LIMIT_TRIP_BIT = 5;
    localparam int RIR_CARRIER_LOSS_BIT = 1;
    localparam int RIR_ALT_PRESENT_BIT = 0;

    typedef struct packed {
        logic [2:0] buildOutSel;
        logic rxGainLimit;
        logic attenPathSel;
        logic attenDepthSel;
        logic attenDisable;
        logic txPowerDown;
    } lineIfaceCtrl_type;

    typedef struct packed {
        logic pos;
        logic neg;
    } symbol_type;

    typedef enum logic [2:0] {
        SHAPE_75_NORMAL,
        SHAPE_120_NORMAL,
        SHAPE_75_PROTECT,
        SHAPE_120_PROTECT,
        SHAPE_75_HRL_115,
        SHAPE_75_HRL_136,
        SHAPE_RESERVED
    } waveShape_type;
endpackage : e1_line_clock_pkg

//--- logic/e1_line_clock_jitter_control.sv
// Digital side of the E1 line interface: clock recovery, carrier loss, alternate clock
// detection, receive clock selection, jitter attenuator, crystal pull and build-out decode.
// Assumes all pins but ref_clk, rst_n and the register port are asynchronous to ref_clk and are at least four times slower.
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module e1_line_clock_jitter_control
    import e1_line_clock_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic rx_line_pos,
    input wire logic rx_line_neg,
    input wire logic alternate_clock_in,
    input wire logic tx_clock_in,
    input wire symbol_type txData,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdData,
    output logic rxClock,
    output symbol_type rxData,
    output logic rx_carrier_loss,
    output logic altClockPresent,
    output logic tx_line_pos,
    output logic tx_line_neg,
    output logic txLineOe_n,
    output logic crystalLoadAdd,
    output waveShape_type waveShape
);
    function automatic waveShape_type decodeShape(input logic [2:0] code);
        case (code)
            3'h0: decodeShape = SHAPE_75_NORMAL;
            3'h1: decodeShape = SHAPE_120_NORMAL;
            3'h2: decodeShape = SHAPE_75_PROTECT;
            3'h3: decodeShape = SHAPE_120_PROTECT;
            3'h4: decodeShape = SHAPE_75_HRL_115;
            3'h6: decodeShape = SHAPE_75_HRL_136;
            default: decodeShape = SHAPE_RESERVED;
        endcase
    endfunction : decodeShape

    lineIfaceCtrl_type ctrl_r;
    logic limitTrip_r;
    logic [5:0] s1_r, s2_r, s3_r, pinLvl_r;
    logic [5:0] pinRise;
    logic [PHASE_W-1:0] phase_r;
    logic [PHASE_W:0] phaseSum;
    logic pulseSeen_r;
    symbol_type uiSym_r;
    symbol_type recSym_r;
    logic recClk_r;
    logic [7:0] zeroRun_r;
    logic [11:0] altWin_r;
    logic [12:0] altCount_r;
    logic altPresent_r;
    logic [XACC_W-1:0] xAcc_r;
    logic [XACC_W:0] xSum;
    logic [XACC_W-1:0] xInc;
    logic [3:0] halfCnt_r;
    logic [3:0] divLen_r;
    logic jaClk_r;
    logic jaTick;
    symbol_type buf_r [DEPTH_DEEP];
    logic [6:0] wrPtr_r, rdPtr_r;
    logic [7:0] fill;
    logic [7:0] depth, limMargin;
    logic depthPrev_r;
    logic inRxPath, inTxPath, centred;
    logic jaWr;
    symbol_type jaWrSym;
    symbol_type jaOut_r;
    logic txTick;
    symbol_type txSym_r;
    logic [4:0] txWidth_r;
    logic rdHit;

    // Pin synchronisers: s1 feeds only s2; a level change counts once s2 and s3 agree
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            pinLvl_r <= '0;
        end else begin
            s1_r <= {txData.neg, txData.pos, tx_clock_in, alternate_clock_in,
                     rx_line_neg, rx_line_pos};
            s2_r <= s1_r;
            s3_r <= s2_r;
            pinLvl_r <= (s2_r & s3_r) | (pinLvl_r & (s2_r | s3_r));
        end
    end
    assign pinRise = ((s2_r & s3_r) | (pinLvl_r & (s2_r | s3_r))) & ~pinLvl_r;

    // Oversampled recovery: phase counts 32 slots per unit interval
    assign phaseSum = {1'b0, phase_r} + {1'b0, UI_INC};
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            phase_r <= '0;
            pulseSeen_r <= 1'b0;
            uiSym_r <= '0;
            recSym_r <= '0;
            recClk_r <= 1'b0;
        end else begin
            // Re-aligning on each pulse can cut a high phase short
            if (pinRise[0] || pinRise[1]) begin
                phase_r <= PHASE_ALIGN;
            end else begin
                phase_r <= phaseSum[PHASE_W-1:0];
            end
            recClk_r <= phase_r[PHASE_W-1];
            if (phaseSum[PHASE_W] && !(pinRise[0] || pinRise[1])) begin
                recSym_r <= uiSym_r;
                pulseSeen_r <= 1'b0;
                uiSym_r <= '0;
            end else if (pinRise[0] || pinRise[1]) begin
                pulseSeen_r <= 1'b1;
                uiSym_r <= '{pos: pinRise[0], neg: pinRise[1]};
            end
        end
    end
    wire uiEnd = phaseSum[PHASE_W] && !(pinRise[0] || pinRise[1]);
    wire recTick = !recClk_r && phase_r[PHASE_W-1];

    // Carrier loss after a run of unit intervals with no bipolar pulse
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            zeroRun_r <= '0;
            rx_carrier_loss <= 1'b1;
        end else if (pinRise[0] || pinRise[1]) begin
            zeroRun_r <= '0;
            rx_carrier_loss <= 1'b0;
        end else if (uiEnd && !pulseSeen_r) begin
            if (zeroRun_r == LOS_ZEROS) begin
                rx_carrier_loss <= 1'b1;
            end else begin
                zeroRun_r <= zeroRun_r + 8'h01;
            end
        end
    end

    // Alternate clock presence: edge count per window must sit in a plausible band
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            altWin_r <= '0;
            altCount_r <= '0;
            altPresent_r <= 1'b0;
        end else begin
            altWin_r <= altWin_r + 12'h001;
            if (altWin_r == 12'(ALT_WINDOW_CYC - 1)) begin
                altPresent_r <= (altCount_r >= ALT_MIN) && (altCount_r <= ALT_MAX);
                altCount_r <= '0;
            end else if (pinRise[2]) begin
                altCount_r <= altCount_r + 13'h0001;
            end
        end
    end
    assign altClockPresent = altPresent_r;

    // Register port
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctrl_r <= lineIfaceCtrl_type'(LINE_IFACE_CTRL_RESET);
        end else if (regWr && regAddr == ADDR_LINE_IFACE_CTRL) begin
            ctrl_r <= lineIfaceCtrl_type'(regWrData);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            regRdData <= '0;
        end else if (regRd) begin
            case (regAddr)
                ADDR_LINE_IFACE_CTRL: regRdData <= ctrl_r;
                ADDR_RX_INFO_REG: begin
                    regRdData <= '0;
                    regRdData[RIR_LIMIT_TRIP_BIT] <= limitTrip_r;
                    regRdData[RIR_CARRIER_LOSS_BIT] <= rx_carrier_loss;
                    regRdData[RIR_ALT_PRESENT_BIT] <= altPresent_r;
                end
                default: regRdData <= '0;
            endcase
        end
    end

    // Attenuator placement and source of its write clock
    assign inRxPath = !ctrl_r.attenDisable && !ctrl_r.attenPathSel;
    assign inTxPath = !ctrl_r.attenDisable && ctrl_r.attenPathSel;
    // With no line and no alternate clock the receive path runs on the free crystal
    assign centred = inRxPath && rx_carrier_loss && !altPresent_r;
    always_comb begin
        jaWr = 1'b0;
        jaWrSym = '0;
        if (inTxPath) begin
            jaWr = pinRise[3];
            jaWrSym = '{pos: pinLvl_r[4], neg: pinLvl_r[5]};
        end else if (inRxPath && !rx_carrier_loss) begin
            jaWr = recTick;
            jaWrSym = recSym_r;
        end else if (inRxPath && altPresent_r) begin
            jaWr = pinRise[2];
        end
    end

    // Crystal model with switched load capacitance
    assign xInc = crystalLoadAdd ? XTAL_HALF_INC - XTAL_PULL_INC
                                 : XTAL_HALF_INC + XTAL_PULL_INC;
    assign xSum = {1'b0, xAcc_r} + {1'b0, (centred ? XTAL_HALF_INC : xInc)};
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            xAcc_r <= '0;
            crystalLoadAdd <= 1'b0;
        end else begin
            xAcc_r <= xSum[XACC_W-1:0];
            // Buffer draining below half means the crystal runs fast: add load
            crystalLoadAdd <= (fill < (depth >> 1));
        end
    end

    // Output divider, normally 8 half periods; 7 or 9 near the buffer limits
    assign depth = ctrl_r.attenDepthSel ? 8'(DEPTH_SHALLOW) : 8'(DEPTH_DEEP);
    assign limMargin = ctrl_r.attenDepthSel ? LIM_SHALLOW : LIM_DEEP;
    assign fill = {1'b0, 7'(wrPtr_r - rdPtr_r)};
    assign jaTick = xSum[XACC_W] && (halfCnt_r == divLen_r - 4'h1);
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            halfCnt_r <= '0;
            divLen_r <= DIV_NOM;
            jaClk_r <= 1'b0;
        end else if (xSum[XACC_W]) begin
            if (jaTick) begin
                halfCnt_r <= '0;
                jaClk_r <= 1'b1;
                if (centred) begin
                    divLen_r <= DIV_NOM;
                end else if (fill > depth - limMargin) begin
                    divLen_r <= DIV_FAST;
                end else if (fill < limMargin) begin
                    divLen_r <= DIV_SLOW;
                end else begin
                    divLen_r <= DIV_NOM;
                end
            end else begin
                halfCnt_r <= halfCnt_r + 4'h1;
                if (halfCnt_r == (divLen_r >> 1) - 4'h1) begin
                    jaClk_r <= 1'b0;
                end
            end
        end
    end

    // Set wins over a software clear in the same cycle
    assign rdHit = regWr && regAddr == ADDR_RX_INFO_REG && regWrData[RIR_LIMIT_TRIP_BIT];
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            limitTrip_r <= 1'b0;
        end else if (jaTick && divLen_r != DIV_NOM) begin
            limitTrip_r <= 1'b1;
        end else if (rdHit) begin
            limitTrip_r <= 1'b0;
        end
    end

    // Elastic bit buffer; a depth change or, at depth 32 only, a full buffer (fill at depth) re-centres the read side
    always_ff @(posedge ref_clk) begin
        if (jaWr) begin
            buf_r[wrPtr_r] <= jaWrSym;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wrPtr_r <= '0;
            rdPtr_r <= 7'(0 - DEPTH_DEEP / 2);
            depthPrev_r <= 1'b0;
            jaOut_r <= '0;
        end else begin
            depthPrev_r <= ctrl_r.attenDepthSel;
            if (jaWr) begin
                wrPtr_r <= wrPtr_r + 7'h01;
            end
            if (depthPrev_r != ctrl_r.attenDepthSel || fill >= depth) begin
                rdPtr_r <= wrPtr_r - 7'(depth >> 1);
            end else if (jaTick) begin
                rdPtr_r <= rdPtr_r + 7'h01;
                jaOut_r <= buf_r[rdPtr_r];
            end
        end
    end

    // Receive clock source selection
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rxClock <= 1'b0;
            rxData <= '0;
        end else if (inRxPath) begin
            rxClock <= jaClk_r;
            rxData <= (rx_carrier_loss) ? symbol_type'('0) : jaOut_r;
        end else if (!rx_carrier_loss) begin
            rxClock <= recClk_r;
            rxData <= recSym_r;
        end else if (altPresent_r) begin
            rxClock <= pinLvl_r[2];
            rxData <= '0;
        end else if (inTxPath) begin
            rxClock <= jaClk_r;
            rxData <= '0;
        end else begin
            rxClock <= jaClk_r;
            rxData <= '0;
        end
    end

    // Transmit pulses: fixed half-UI width from the launching edge only
    assign txTick = inTxPath ? jaTick : pinRise[3];
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            txSym_r <= '0;
            txWidth_r <= '0;
        end else if (txTick) begin
            txSym_r <= inTxPath ? jaOut_r : symbol_type'({pinLvl_r[4], pinLvl_r[5]});
            txWidth_r <= 5'(HALF_UI_CYC);
        end else if (txWidth_r != 5'h00) begin
            txWidth_r <= txWidth_r - 5'h01;
        end
    end
    assign tx_line_pos = !ctrl_r.txPowerDown && txWidth_r != 5'h00 && txSym_r.pos;
    assign tx_line_neg = !ctrl_r.txPowerDown && txWidth_r != 5'h00 && txSym_r.neg;
    assign txLineOe_n = ctrl_r.txPowerDown;
    assign waveShape = decodeShape(ctrl_r.buildOutSel);
endmodule : e1_line_clock_jitter_control

//--- bench/e1_line_clock_jitter_control_assertions.sv
// Port-level checks for the E1 line clock and jitter control block.
// Assumes a bind to the top module; sees its ports only.
`timescale 1ns/1ps
module e1_line_clock_checker
    import e1_line_clock_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic rx_line_pos,
    input wire logic rx_line_neg,
    input wire logic alternate_clock_in,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regRdData,
    input wire logic rxClock,
    input wire logic rx_carrier_loss,
    input wire logic altClockPresent,
    input wire logic txLineOe_n,
    input wire waveShape_type waveShape
);
    localparam waveShape_type SHAPES [8] = '{SHAPE_75_NORMAL, SHAPE_120_NORMAL,
        SHAPE_75_PROTECT, SHAPE_120_PROTECT, SHAPE_75_HRL_115, SHAPE_RESERVED,
        SHAPE_75_HRL_136, SHAPE_RESERVED};
    logic [15:0] lineQuiet_r;
    logic [15:0] altQuiet_r;
    logic [7:0] ctrl_r;
    logic ctrlWr;
    assign ctrlWr = regWr && regAddr == ADDR_LINE_IFACE_CTRL;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Saturating counters so long silences never wrap into a false pass
    always_ff @(posedge ref_clk) begin
        if (!rst_n || rx_line_pos || rx_line_neg) lineQuiet_r <= 16'h0000;
        else if (lineQuiet_r != 16'hFFFF) lineQuiet_r <= lineQuiet_r + 16'h0001;
    end
    always_ff @(posedge ref_clk) begin
        if (!rst_n || $changed(alternate_clock_in)) altQuiet_r <= 16'h0000;
        else if (altQuiet_r != 16'hFFFF) altQuiet_r <= altQuiet_r + 16'h0001;
    end
    always_ff @(posedge ref_clk) begin
        if (!rst_n) ctrl_r <= LINE_IFACE_CTRL_RESET;
        else if (ctrlWr) ctrl_r <= regWrData;
    end
    AST_PD_OE: assert property (
        ctrlWr |=> txLineOe_n == $past(regWrData[0])) else $error("oe does not follow bit 0");
    AST_SHAPE_STD: assert property (
        ctrlWr && !regWrData[7] |=> waveShape == SHAPES[$past(regWrData[7:5])])
        else $error("standard shape decode wrong");
    AST_SHAPE_HRL: assert property (
        ctrlWr && regWrData[7] |=> waveShape == SHAPES[$past(regWrData[7:5])])
        else $error("high return loss shape decode wrong");
    AST_RD_CTRL: assert property (
        regRd && regAddr == ADDR_LINE_IFACE_CTRL |=> regRdData == $past(ctrl_r))
        else $error("control readback wrong");
    AST_RIR_LIVE: assert property (
        regRd && regAddr == ADDR_RX_INFO_REG
        |=> regRdData[1:0] == {$past(rx_carrier_loss), $past(altClockPresent)})
        else $error("info status bits wrong");
    AST_LOSS_CLEAR: assert property (
        $fell(rx_carrier_loss) |-> lineQuiet_r <= 16'h0010) else $error("loss cleared without pulse");
    AST_LOSS_HOLD: assert property (
        lineQuiet_r > 16'h1F40 |-> rx_carrier_loss) else $error("loss missing on silent line");
    AST_ALT_ABSENT: assert property (
        altQuiet_r > 16'h2328 |-> !altClockPresent) else $error("alternate clock seen on still pin");
    AST_RXCLK_RUNS: assert property (
        !rx_carrier_loss && rxClock |-> ##[1:100] !rxClock) else $error("receive clock stuck high");
    CVR_LOSS_CLEAR: cover property ($fell(rx_carrier_loss));
    CVR_ALT_FOUND: cover property ($rose(altClockPresent));
    CVR_POWER_DOWN: cover property (ctrlWr && regWrData[0]);
endmodule : e1_line_clock_checker

bind e1_line_clock_jitter_control e1_line_clock_checker checker_i (.ref_clk, .rst_n,
    .rx_line_pos, .rx_line_neg, .alternate_clock_in, .regAddr, .regWrData, .regWr, .regRd,
    .regRdData, .rxClock, .rx_carrier_loss, .altClockPresent, .txLineOe_n, .waveShape);

//--- bench/e1_line_partner.sv
// Far side model: E1 line marks, alternate clock and transmit clock, all at line rate.
// Assumes the testbench turns each source on and off; sources stay low while off.
`timescale 1ns/1ps
module e1_line_partner (
    input wire logic lineOn,
    input wire logic altOn,
    input wire logic txOn,
    input wire logic [9:0] txHighNs,
    output logic rx_line_pos,
    output logic rx_line_neg,
    output logic alternate_clock_in,
    output logic tx_clock_in
);
    logic markPos;
    // All-ones AMI: marks alternate polarity, half a unit interval wide
    initial begin
        rx_line_pos = 1'b0;
        rx_line_neg = 1'b0;
        markPos = 1'b1;
        forever begin
            #244;
            if (lineOn) begin
                rx_line_pos = markPos;
                rx_line_neg = !markPos;
                markPos = !markPos;
            end
            #244;
            rx_line_pos = 1'b0;
            rx_line_neg = 1'b0;
        end
    end
    // An unused alternate clock pin is tied low
    initial begin
        alternate_clock_in = 1'b0;
        forever begin
            #244;
            alternate_clock_in = altOn;
            #244;
            alternate_clock_in = 1'b0;
        end
    end
    initial begin
        tx_clock_in = 1'b0;
        forever begin
            #(488 - txHighNs);
            tx_clock_in = txOn;
            #(txHighNs);
            tx_clock_in = 1'b0;
        end
    end
endmodule : e1_line_partner

//--- bench/tb.sv
// Self-checking testbench for the E1 line clock and jitter control block.
// Assumes the partner model on the line side and the bound checker.
`timescale 1ns/1ps
module tb
    import e1_line_clock_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    symbol_type txData = '0;
    logic lineOn = 1'b0;
    logic altOn = 1'b0;
    logic txOn = 1'b0;
    logic [9:0] txHighNs = 10'h0F4;
    logic [7:0] regRdData;
    logic rxClock;
    symbol_type rxData;
    logic rx_carrier_loss;
    logic altClockPresent;
    logic tx_line_pos;
    logic tx_line_neg;
    logic txLineOe_n;
    logic crystalLoadAdd;
    waveShape_type waveShape;
    logic rxPos;
    logic rxNeg;
    logic altClk;
    logic txClk;
    int errorCnt = 0;
    int nTests = 0;
    int cycleCnt = 0;
    logic [7:0] rd;
    localparam waveShape_type SHAPES [8] = '{SHAPE_75_NORMAL, SHAPE_120_NORMAL,
        SHAPE_75_PROTECT, SHAPE_120_PROTECT, SHAPE_75_HRL_115, SHAPE_RESERVED,
        SHAPE_75_HRL_136, SHAPE_RESERVED};

    always #10 ref_clk = !ref_clk;

    e1_line_partner line_i (.lineOn(lineOn), .altOn(altOn), .txOn(txOn), .txHighNs(txHighNs),
        .rx_line_pos(rxPos), .rx_line_neg(rxNeg), .alternate_clock_in(altClk),
        .tx_clock_in(txClk));

    e1_line_clock_jitter_control DUT (.ref_clk(ref_clk), .rst_n(rst_n), .rx_line_pos(rxPos),
        .rx_line_neg(rxNeg), .alternate_clock_in(altClk), .tx_clock_in(txClk),
        .txData(txData), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd), .regRdData(regRdData), .rxClock(rxClock), .rxData(rxData),
        .rx_carrier_loss(rx_carrier_loss), .altClockPresent(altClockPresent),
        .tx_line_pos(tx_line_pos), .tx_line_neg(tx_line_neg), .txLineOe_n(txLineOe_n),
        .crystalLoadAdd(crystalLoadAdd), .waveShape(waveShape));

    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", nTests, errorCnt);
        if (errorCnt == 0 && nTests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_sim

    // Budget covers about 30k cycles of scenarios with margin
    always @(posedge ref_clk) begin
        cycleCnt++;
        if (cycleCnt == 100000) begin
            errorCnt++;
            end_sim();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick

    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        nTests++;
        if (got !== exp) begin
            errorCnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check8

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge ref_clk);
        regWr <= 1'b0;
        #1;
    endtask : reg_write

    // Read data appear in the cycle after the strobe and hold until the next read
    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1;
        d = regRdData;
    endtask : reg_read

    task automatic rxclk_rate(input string what);
        int cnt;
        logic prev;
        cnt = 0;
        prev = rxClock;
        repeat (1000) begin
            tick(1);
            if (rxClock && !prev) cnt++;
            prev = rxClock;
        end
        check8(what, 8'h01, {7'h00, cnt >= 38 && cnt <= 44});
    endtask : rxclk_rate

    task automatic t_registers;
        check8("loss after reset", 8'h01, {7'h00, rx_carrier_loss});
        reg_read(ADDR_RX_INFO_REG, rd);
        check8("info after reset", 8'h02, rd);
        for (int c = 0; c < 8; c++) begin
            reg_write(ADDR_LINE_IFACE_CTRL, {c[2:0], 5'h00});
            check8("wave shape", {5'h00, SHAPES[c]}, {5'h00, waveShape});
        end
        reg_write(ADDR_LINE_IFACE_CTRL, 8'h02);
        reg_read(ADDR_LINE_IFACE_CTRL, rd);
        check8("disable readback", 8'h02, rd);
        reg_write(ADDR_LINE_IFACE_CTRL, 8'h01);
        check8("oe in power down", 8'h01, {7'h00, txLineOe_n});
        reg_write(ADDR_LINE_IFACE_CTRL, 8'h00);
        check8("oe in service", 8'h00, {7'h00, txLineOe_n});
        reg_write(8'h30, 8'hFF);
        reg_read(8'h30, rd);
        check8("unmapped read", 8'h00, rd);
        reg_read(ADDR_LINE_IFACE_CTRL, rd);
        check8("ctrl after stray write", 8'h00, rd);
    endtask : t_registers

    task automatic t_line;
        lineOn = 1'b1;
        for (int i = 0; i < 2000 && rx_carrier_loss !== 1'b0; i++) tick(1);
        check8("loss with line", 8'h00, {7'h00, rx_carrier_loss});
        rxclk_rate("recovered clock rate");
        lineOn = 1'b0;
        tick(8200);
        // Centred divider never trips, so a clear must stick
        reg_write(ADDR_RX_INFO_REG, 8'h20);
        reg_read(ADDR_RX_INFO_REG, rd);
        check8("info loss bit", 8'h01, {7'h00, rd[RIR_CARRIER_LOSS_BIT]});
        check8("trip cleared", 8'h00, {7'h00, rd[RIR_LIMIT_TRIP_BIT]});
        rxclk_rate("centred crystal rate");
    endtask : t_line

    task automatic t_alt;
        altOn = 1'b1;
        tick(8300);
        reg_read(ADDR_RX_INFO_REG, rd);
        check8("alt present bit", 8'h01, {7'h00, rd[RIR_ALT_PRESENT_BIT]});
        // Fill is arbitrary after the centred phase; a depth change re-centres it
        reg_write(ADDR_LINE_IFACE_CTRL, 8'h04);
        rxclk_rate("alternate clock rate");
        altOn = 1'b0;
        tick(9100);
        check8("alt absent", 8'h00, {7'h00, altClockPresent});
    endtask : t_alt

    task automatic t_tx;
        int w;
        txData <= '{pos: 1'b1, neg: 1'b0};
        txOn = 1'b1;
        for (int d = 0; d < 2; d++) begin
            txHighNs = d == 0 ? 10'h0F4 : 10'h064;
            tick(100);
            // Start from a gap so a pulse already under way is not measured short
            for (int i = 0; i < 100 && tx_line_pos !== 1'b0; i++) tick(1);
            for (int i = 0; i < 100 && tx_line_pos !== 1'b1; i++) tick(1);
            w = 0;
            while (tx_line_pos === 1'b1 && w < 40) begin
                tick(1);
                w++;
            end
            check8("tx pulse width", 8'(HALF_UI_CYC), 8'(w));
            check8("tx neg idle", 8'h00, {7'h00, tx_line_neg});
        end
        reg_write(ADDR_LINE_IFACE_CTRL, 8'h08);
        tick(200);
        rxclk_rate("tx clock via attenuator");
        txOn = 1'b0;
    endtask : t_tx

    initial begin
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        tick(1);
        t_registers();
        t_line();
        t_alt();
        t_tx();
        end_sim();
    end
endmodule : tb
